// >>> shared/aic_pkg.sv
package aic_pkg;
    // command codes
    localparam logic [7:0] CMD_NOP         = 8'h00;
    localparam logic [7:0] CMD_INIT_PARAMS = 8'h91;
    localparam logic [7:0] CMD_IDLE_IMM    = 8'he1;
    localparam logic [7:0] CMD_IDLE        = 8'he3;
    localparam logic [7:0] CMD_RD_BUF      = 8'he4;
    localparam logic [7:0] CMD_WR_BUF      = 8'he8;

    // timing
    localparam int CLK_PERIOD_NS  = 25;
    localparam int SECOND_NS      = 1_000_000_000;
    localparam int SEC_CYCLES_DEF = SECOND_NS / CLK_PERIOD_NS;
    localparam int TMR_W          = 15;
    localparam logic [TMR_W-1:0] SPINDOWN_S = 15'd60;
    localparam logic [TMR_W-1:0] STEP_5S    = 15'd5;
    localparam logic [TMR_W-1:0] STEP_30M_S = 15'd1800;
    localparam logic [TMR_W-1:0] T_21M_S    = 15'd1260;
    localparam logic [TMR_W-1:0] T_8H_S     = 15'd28800;
    localparam logic [TMR_W-1:0] T_2115_S   = 15'd1275;
    localparam logic [7:0] SC_5S_MAX  = 8'hf0;
    localparam logic [7:0] SC_30M_MAX = 8'hfb;
    localparam logic [7:0] SC_21M     = 8'hfc;
    localparam logic [7:0] SC_8H      = 8'hfd;
    localparam logic [7:0] SC_2115    = 8'hff;

    // sector buffer: 512 bytes as 16-bit words
    localparam int BUF_BYTES = 512;
    localparam int BUF_WORDS = BUF_BYTES / 2;
    localparam int PTR_W     = $clog2(BUF_WORDS);

    // identify words
    localparam logic [7:0] IDW_UDMA   = 8'd88;
    localparam logic [7:0] IDW_APM    = 8'd91;
    localparam logic [7:0] IDW_MPW    = 8'd92;
    localparam logic [7:0] IDW_LBA0   = 8'd100;
    localparam logic [7:0] IDW_LBA1   = 8'd101;
    localparam logic [7:0] IDW_LBA2   = 8'd102;
    localparam logic [7:0] IDW_LBA3   = 8'd103;
    localparam logic [7:0] IDW_SECTOR = 8'd106;
    localparam logic [7:0] IDW_SEC    = 8'd128;
    localparam logic [7:0] IDW_INTEG  = 8'd255;
    localparam logic [7:0]  UDMA_SUPPORTED = 8'h7f;
    localparam logic [7:0]  APM_DEFAULT    = 8'h80;
    localparam logic [15:0] MPW_REV        = 16'hfffe;
    localparam logic [15:0] SECTOR_WORD    = 16'h4000;
    localparam logic [7:0]  ID_SIGNATURE   = 8'ha5;
    // security word: supported, enhanced erase fixed at one
    localparam int SEC_B_SUPP  = 0;
    localparam int SEC_B_ENH   = 5;
    localparam int SEC_B_LEVEL = 8;

    typedef enum logic [1:0] {PWR_ACTIVE, PWR_IDLE, PWR_STANDBY} aic_pwr_type;
    typedef enum logic [1:0] {ST_READY, ST_EXEC, ST_WR_DATA, ST_RD_DATA} aic_state_type;

    function automatic logic [TMR_W-1:0] aic_timeout_s(input logic [7:0] sc);
        logic [TMR_W-1:0] t;
        t = '0;
        if (sc != 8'h00 && sc <= SC_5S_MAX)
            t = TMR_W'(sc) * STEP_5S;
        else if (sc > SC_5S_MAX && sc <= SC_30M_MAX)
            t = TMR_W'(sc - SC_5S_MAX) * STEP_30M_S;
        else if (sc == SC_21M)
            t = T_21M_S;
        else if (sc == SC_8H)
            t = T_8H_S;
        else if (sc == SC_2115)
            t = T_2115_S;
        return t;
    endfunction : aic_timeout_s
endpackage : aic_pkg

// >>> shared/aic_id_if.sv
`timescale 1ns/1ps
interface aic_id_if;
    logic        udma_act_en;
    logic [2:0]  udma_act_mode;
    logic [4:0]  sec_state;
    logic        sec_level;
    logic [7:0]  apm_level;
    logic [47:0] max_lba;
    logic [7:0]  word_idx;
    logic [15:0] word_data;

    modport core (output udma_act_en, udma_act_mode, sec_state, sec_level, apm_level,
                  max_lba, word_idx, input word_data);
    modport ident (input udma_act_en, udma_act_mode, sec_state, sec_level, apm_level,
                   max_lba, word_idx, output word_data);
endinterface : aic_id_if

// >>> rtl/aic_identify.sv
`timescale 1ns/1ps
module aic_identify
    import aic_pkg::*;
(
    aic_id_if.ident id              // identify configuration and word lookup
);
    logic [15:0] w_udma;
    logic [15:0] w_apm;
    logic [15:0] w_sec;
    logic [7:0]  byte_sum;
    logic [7:0]  checksum;

    always_comb
    begin
        w_udma = {8'h00, UDMA_SUPPORTED};
        if (id.udma_act_en)
            w_udma[4'd8 + {1'b0, id.udma_act_mode}] = 1'b1; // RL15
        w_apm = {8'h00, id.apm_level}; // RL18
        w_sec = '0;
        w_sec[SEC_B_SUPP]  = 1'b1; // RL16
        w_sec[SEC_B_ENH]   = 1'b1;
        w_sec[4:1]         = id.sec_state[3:0];
        w_sec[SEC_B_LEVEL] = id.sec_level;
    end

    // words not held by this block read as zero, so only these enter the sum
    always_comb
    begin
        byte_sum = w_udma[7:0] + w_udma[15:8] + w_apm[7:0] + MPW_REV[7:0] + MPW_REV[15:8]
                 + id.max_lba[7:0] + id.max_lba[15:8] + id.max_lba[23:16]
                 + id.max_lba[31:24] + id.max_lba[39:32] + id.max_lba[47:40]
                 + SECTOR_WORD[15:8] + w_sec[7:0] + w_sec[15:8] + ID_SIGNATURE;
        checksum = 8'h00 - byte_sum; // RL21
    end

    always_comb
    begin
        case (id.word_idx)
            IDW_UDMA:   id.word_data = w_udma;
            IDW_APM:    id.word_data = w_apm;
            IDW_MPW:    id.word_data = MPW_REV; // RL20
            IDW_LBA0:   id.word_data = id.max_lba[15:0]; // RL19
            IDW_LBA1:   id.word_data = id.max_lba[31:16];
            IDW_LBA2:   id.word_data = id.max_lba[47:32];
            IDW_LBA3:   id.word_data = 16'h0000;
            IDW_SECTOR: id.word_data = SECTOR_WORD; // RL17
            IDW_SEC:    id.word_data = w_sec;
            IDW_INTEG:  id.word_data = {checksum, ID_SIGNATURE}; // RL21
            default:    id.word_data = 16'h0000;
        endcase
    end
endmodule : aic_identify

// >>> rtl/aic_core.sv
`timescale 1ns/1ps
// Notes on behaviour
// [RL1] idle command: idle mode, ready, interrupt
// [RL2] idle interrupt does not wait for spindle
// [RL3] no spin-up when spindle already turning
// [RL4] nonzero count arms standby timer at once
// [RL5] count decodes to 5 s or 30 min steps
// [RL6] codes 252, 253, 255 special; 254 reserved
// [RL7] one minute in idle, then standby, only while the standby timer is armed
// [RL8] idle immediate: idle, ready, interrupt, timer kept
// [RL9] init parameters: busy, store, ready, interrupt
// [RL10] geometry taken from count and head fields
// [RL11] geometry stored unchecked
// [RL12] nop always aborted
// [RL13] read buffer: drq, ready, interrupt, 512 bytes
// [RL14] write and read buffer share one region
// [RL15] word 88 ultra dma active and supported
// [RL16] word 128 security status, default 0021h
// [RL17] word 106 holds 4000h
// [RL18] word 91 current power management level
// [RL19] words 100-103 maximum lba, low first
// [RL20] word 92 master password revision fffeh
// [RL21] word 255 signature and zero checksum
// [RL22] busy until status posted, one interrupt
module aic_core
    import aic_pkg::*;
#(
    parameter int SEC_CYCLES = SEC_CYCLES_DEF  // clock cycles per second of timer
)
(
    input  wire logic        core_clk,          // clock, 40 MHz
    input  wire logic        reset_n,           // synchronous reset, active low
    input  wire logic        cmd_valid,         // command register written, pulse
    input  wire logic [7:0]  cmd_code,          // command code
    input  wire logic [7:0]  sect_count,        // sector count field
    input  wire logic [7:0]  drive_head,        // drive/head field
    input  wire logic        status_read,       // host read status, clears interrupt
    input  wire logic        wr_strobe,         // buffer word written by host
    input  wire logic [15:0] wr_data,           // buffer write word
    input  wire logic        rd_strobe,         // buffer word taken by host
    input  wire logic        spindle_turning,   // spindle at speed
    input  wire logic        udma_act_en,       // an ultra dma mode is active
    input  wire logic [2:0]  udma_act_mode,     // active ultra dma mode
    input  wire logic [4:0]  sec_state,         // enabled, locked, frozen, expired...
    input  wire logic        sec_level,         // security level maximum
    input  wire logic [7:0]  apm_level,         // current power management value
    input  wire logic [47:0] max_lba,           // maximum user lba
    input  wire logic [7:0]  id_idx,            // identify word index
    output logic             busy,              // bsy status
    output logic             drq,               // drq status
    output logic             intrq,             // interrupt to host, level
    output logic             aborted,           // command aborted error
    output logic [7:0]       sect_per_track,    // stored sectors per track
    output logic [3:0]       head_max,          // stored heads minus one
    output logic [15:0]      rd_data,           // buffer read word
    output logic [15:0]      id_data,           // identify word
    output aic_pwr_type      pwr_mode,          // power mode
    output logic             spin_up_req,       // spin-up request, pulse
    output logic             timer_armed        // automatic standby timer enabled
);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(BUF_WORDS - 1);
    localparam int PRE_W = $clog2(SEC_CYCLES);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(SEC_CYCLES - 1);

    if (SEC_CYCLES < 2)
    begin : g_bad_cycles
        $error("SEC_CYCLES must be at least 2");
    end

    aic_state_type    state;
    logic [7:0]       cmd;
    logic [7:0]       cmd_sc;
    logic [7:0]       cmd_dh;
    logic [PTR_W-1:0] ptr;
    logic [15:0]      buffer [BUF_WORDS];
    logic [PRE_W-1:0] prescale;
    logic             sec_tick;
    logic [TMR_W-1:0] stb_cnt;
    logic [TMR_W-1:0] spin_cnt;
    logic             take_cmd;
    logic             in_exec;
    logic             is_idle_cmd;
    logic             known_cmd;
    logic             wr_last;
    logic             rd_last;

    aic_id_if id_bus ();

    assign id_bus.udma_act_en   = udma_act_en;
    assign id_bus.udma_act_mode = udma_act_mode;
    assign id_bus.sec_state     = sec_state;
    assign id_bus.sec_level     = sec_level;
    assign id_bus.apm_level     = apm_level;
    assign id_bus.max_lba       = max_lba;
    assign id_bus.word_idx      = id_idx;

    aic_identify u_identify (
        .id (id_bus.ident)
    );

    // a command written while busy is ignored, as the host must wait for ready
    assign take_cmd    = cmd_valid && !busy;
    assign in_exec     = (state == ST_EXEC);
    assign is_idle_cmd = (cmd == CMD_IDLE) || (cmd == CMD_IDLE_IMM);
    assign known_cmd   = is_idle_cmd || (cmd == CMD_INIT_PARAMS) ||
                         (cmd == CMD_RD_BUF) || (cmd == CMD_WR_BUF);
    assign wr_last     = (state == ST_WR_DATA) && wr_strobe && (ptr == PTR_LAST);
    assign rd_last     = (state == ST_RD_DATA) && rd_strobe && (ptr == PTR_LAST);

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            state  <= ST_READY;
            busy   <= 1'b0;
            drq    <= 1'b0;
            cmd    <= 8'h00;
            cmd_sc <= 8'h00;
            cmd_dh <= 8'h00;
        end
        else
        begin
            case (state)
                ST_EXEC:
                begin
                    busy <= 1'b0; // RL22
                    if (cmd == CMD_RD_BUF)
                    begin
                        drq   <= 1'b1; // RL13
                        state <= ST_RD_DATA;
                    end
                    else if (cmd == CMD_WR_BUF)
                    begin
                        drq   <= 1'b1;
                        state <= ST_WR_DATA;
                    end
                    else
                        state <= ST_READY;
                end
                default:
                begin
                    if (take_cmd)
                    begin
                        // a new command ends any buffer transfer in progress
                        busy   <= 1'b1; // RL22
                        drq    <= 1'b0;
                        cmd    <= cmd_code;
                        cmd_sc <= sect_count; // RL10
                        cmd_dh <= drive_head;
                        state  <= ST_EXEC;
                    end
                    else if (wr_last || rd_last)
                    begin
                        drq   <= 1'b0;
                        state <= ST_READY;
                    end
                end
            endcase
        end
    end

    // set beats clear when both land in one cycle
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            intrq <= 1'b0;
        else if ((in_exec && cmd != CMD_WR_BUF) || wr_last) // RL1 RL8 RL9 RL13 RL22
            intrq <= 1'b1;
        else if (status_read)
            intrq <= 1'b0;
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            aborted <= 1'b0;
        else if (take_cmd)
            aborted <= 1'b0;
        else if (in_exec && !known_cmd) // RL12
            aborted <= 1'b1;
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            sect_per_track <= 8'h00;
            head_max       <= 4'h0;
        end
        else if (in_exec && cmd == CMD_INIT_PARAMS)
        begin
            // no range check here; the count and head fields are stored as given
            sect_per_track <= cmd_sc; // RL9 RL10 RL11
            head_max       <= cmd_dh[3:0]; // RL10
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            ptr <= '0;
        else if (in_exec)
            ptr <= '0;
        else if ((state == ST_WR_DATA && wr_strobe) || (state == ST_RD_DATA && rd_strobe))
            ptr <= ptr + 1'b1;
    end

    // one region serves both buffer commands so written data reads back
    always_ff @(posedge core_clk)
    begin
        if (state == ST_WR_DATA && wr_strobe)
            buffer[ptr] <= wr_data; // RL14
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            rd_data <= 16'h0000;
        else if (in_exec && cmd == CMD_RD_BUF)
            rd_data <= buffer[0]; // RL13 RL14
        else if (state == ST_RD_DATA && rd_strobe)
            rd_data <= buffer[ptr + 1'b1];
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            id_data <= 16'h0000;
        else
            id_data <= id_bus.word_data;
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            prescale <= '0;
            sec_tick <= 1'b0;
        end
        else
        begin
            sec_tick <= (prescale == PRE_LAST);
            prescale <= (prescale == PRE_LAST) ? '0 : prescale + 1'b1;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            spin_up_req <= 1'b0;
        else
            spin_up_req <= in_exec && is_idle_cmd && !spindle_turning; // RL3
    end

    // standby timer: expiry while active starts the automatic idle sequence
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            timer_armed <= 1'b0;
            stb_cnt     <= '0;
        end
        else if (in_exec && cmd == CMD_IDLE)
        begin
            // reserved code 254 decodes to zero and leaves the timer off
            timer_armed <= (aic_timeout_s(cmd_sc) != '0); // RL4 RL5 RL6
            stb_cnt     <= aic_timeout_s(cmd_sc); // RL4
        end
        else if (timer_armed && sec_tick && stb_cnt != '0)
            stb_cnt <= stb_cnt - 1'b1;
    end

    // idle interrupt goes out from the exec state while spin-down runs on
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            pwr_mode <= PWR_ACTIVE;
            spin_cnt <= '0;
        end
        else if (in_exec && is_idle_cmd)
        begin
            pwr_mode <= PWR_IDLE; // RL1 RL2 RL8
            spin_cnt <= SPINDOWN_S; // RL7
        end
        else if (timer_armed && pwr_mode == PWR_ACTIVE && sec_tick && stb_cnt == TMR_W'(1))
        begin
            pwr_mode <= PWR_IDLE;
            spin_cnt <= SPINDOWN_S;
        end
        else if (timer_armed && pwr_mode == PWR_IDLE && sec_tick)
        begin
            if (spin_cnt <= TMR_W'(1))
                pwr_mode <= PWR_STANDBY; // RL7
            else
                spin_cnt <= spin_cnt - 1'b1;
        end
    end
endmodule : aic_core

// >>> test/aic_core_asserts.sv
`timescale 1ns/1ps
module aic_core_asserts
    import aic_pkg::*;
(
    input logic        core_clk,         // clock
    input logic        reset_n,          // sync reset
    input logic        cmd_valid,        // command strobe
    input logic [7:0]  cmd_code,         // command code
    input logic [7:0]  sect_count,       // count field
    input logic [7:0]  drive_head,       // head field
    input logic        status_read,      // status read
    input logic        spindle_turning,  // spindle at speed
    input logic [7:0]  id_idx,           // identify index
    input logic        busy,             // bsy
    input logic        drq,              // drq
    input logic        intrq,            // interrupt
    input logic        aborted,          // abort error
    input logic [7:0]  sect_per_track,   // stored sectors
    input logic [3:0]  head_max,         // stored heads
    input logic [15:0] id_data,          // identify word
    input aic_pwr_type pwr_mode,         // power mode
    input logic        spin_up_req,      // spin-up pulse
    input logic        timer_armed       // standby timer on
);
    // a write while busy is dropped, so only this counts as a command
    wire taken = cmd_valid && !busy;

    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    cmd_busy_a: assert property (taken |=> busy)
        else $error("busy not raised by command");
    busy_short_a: assert property (busy |=> !busy)
        else $error("busy held too long");
    idle_done_a: assert property (
        (taken && cmd_code == CMD_IDLE) |-> ##2 (!busy && intrq && pwr_mode == PWR_IDLE))
        else $error("idle command not completed");
    idle_imm_a: assert property (
        (taken && cmd_code == CMD_IDLE_IMM) |-> ##2
        (intrq && pwr_mode == PWR_IDLE && timer_armed == $past(timer_armed, 2)))
        else $error("idle immediate wrong");
    spin_skip_a: assert property (
        (taken && cmd_code == CMD_IDLE && spindle_turning) |=> !spin_up_req [*2])
        else $error("spin-up while spinning");
    spin_req_a: assert property (
        (taken && cmd_code == CMD_IDLE && !spindle_turning) |-> ##2 spin_up_req)
        else $error("no spin-up request");
    timer_arm_a: assert property (
        (taken && cmd_code == CMD_IDLE) |-> ##2
        (timer_armed == ($past(sect_count, 2) != 8'h00 && $past(sect_count, 2) != 8'hfe)))
        else $error("standby timer enable wrong");
    init_geom_a: assert property (
        (taken && cmd_code == CMD_INIT_PARAMS) |-> ##2 (intrq && !aborted
        && sect_per_track == $past(sect_count, 2) && head_max == 4'($past(drive_head, 2))))
        else $error("geometry not stored");
    nop_abort_a: assert property (
        (taken && cmd_code == CMD_NOP) |-> ##2 (aborted && intrq))
        else $error("nop not aborted");
    rd_buf_a: assert property (
        (taken && cmd_code == CMD_RD_BUF) |-> ##2 (drq && intrq && !busy))
        else $error("read buffer setup wrong");
    int_clear_a: assert property ((status_read && !busy && !drq) |=> !intrq)
        else $error("interrupt not cleared");
    sector_word_a: assert property (id_idx == IDW_SECTOR |=> id_data == SECTOR_WORD)
        else $error("sector size word wrong");
endmodule : aic_core_asserts

bind aic_core aic_core_asserts u_asserts (.*);

// >>> test/aic_host_model.sv
`timescale 1ns/1ps
module aic_host_model
(
    input  logic        core_clk,     // clock
    output logic        cmd_valid,    // command strobe
    output logic [7:0]  cmd_code,     // command code
    output logic [7:0]  sect_count,   // count field
    output logic [7:0]  drive_head,   // head field
    output logic        status_read,  // status read pulse
    output logic        wr_strobe,    // buffer write pulse
    output logic [15:0] wr_data,      // buffer write word
    output logic        rd_strobe     // buffer read pulse
);
    initial
    begin
        {cmd_valid, status_read, wr_strobe, rd_strobe} = 4'h0;
        {cmd_code, sect_count, drive_head} = 24'h0;
        wr_data = 16'h0000;
    end

    // twice holds the strobe a second edge with a flipped code, to be refused
    task automatic send_cmd(input logic [7:0] code, input logic [7:0] sc,
                            input logic [7:0] dh, input bit twice = 1'b0);
        {status_read, wr_strobe, rd_strobe} = 3'h0;
        cmd_valid  = 1'b1;
        cmd_code   = code;
        sect_count = sc;
        drive_head = dh;
        repeat (twice ? 2 : 1)
        begin
            @(posedge core_clk);
            #1;
            cmd_code = ~code;
        end
        cmd_valid  = 1'b0;
        sect_count = ~sc;
        drive_head = ~dh;
    endtask : send_cmd

    // kind 0 status read, 1 buffer write, 2 buffer read; held until the next strobe or send_cmd
    task automatic strobe(input logic [1:0] kind, input logic [15:0] data);
        status_read = kind == 2'h0;
        wr_strobe   = kind == 2'h1;
        rd_strobe   = kind == 2'h2;
        wr_data     = data;
        @(posedge core_clk);
        #1;
    endtask : strobe
endmodule : aic_host_model

// >>> test/aic_core_tb.sv
`timescale 1ns/1ps
module aic_core_tb
    import aic_pkg::*;
;
    typedef struct packed {
        logic [7:0] code;
        logic [7:0] sc;
        logic [4:0] exp;  // drq, irq, abort, armed, idle
    } aic_row_type;

    logic        core_clk, reset_n, cmd_valid, status_read, wr_strobe, rd_strobe;
    logic        spindle_turning, udma_act_en, sec_level;
    logic        busy, drq, intrq, aborted, spin_up_req, timer_armed;
    logic [2:0]  udma_act_mode;
    logic [4:0]  sec_state;
    logic [7:0]  cmd_code, sect_count, drive_head, apm_level, id_idx, sect_per_track;
    logic [3:0]  head_max;
    logic [15:0] wr_data, rd_data, id_data;
    logic [47:0] max_lba;
    aic_pwr_type pwr_mode;
    int          checked, failures, cycles, n;
    logic [7:0]  idx_list [11] = '{88, 91, 92, 100, 101, 102, 103, 106, 128, 255, 0};
    aic_row_type rows [16] = '{
        '{8'he3, 8'h00, 5'b01001}, '{8'he3, 8'h01, 5'b01011}, '{8'he1, 8'h00, 5'b01011},
        '{8'he3, 8'hf0, 5'b01011}, '{8'he3, 8'hf1, 5'b01011}, '{8'he3, 8'hfb, 5'b01011},
        '{8'he3, 8'hfc, 5'b01011}, '{8'he3, 8'hfd, 5'b01011}, '{8'he3, 8'hfe, 5'b01001},
        '{8'he1, 8'h00, 5'b01001}, '{8'he3, 8'hff, 5'b01011}, '{8'h00, 8'h00, 5'b01110},
        '{8'h5a, 8'h00, 5'b01110}, '{8'h91, 8'hff, 5'b01010}, '{8'he4, 8'h00, 5'b11010},
        '{8'he8, 8'h00, 5'b10010}};

    aic_core #(.SEC_CYCLES(4)) dut (.*);

    aic_host_model host (.*);

    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask : tick

    task automatic check_bit(input logic got, input logic exp, input string msg);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : check_bit

    task automatic check_word(input logic [15:0] got, input logic [15:0] exp, input string msg);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask : check_word

    function automatic logic [15:0] exp_word(input logic [7:0] idx);
        case (idx)
            8'd88:   return {udma_act_en ? 8'h01 << udma_act_mode : 8'h00, 8'h7f};
            8'd91:   return {8'h00, apm_level};
            8'd92:   return 16'hfffe;
            8'd100:  return max_lba[15:0];
            8'd101:  return max_lba[31:16];
            8'd102:  return max_lba[47:32];
            8'd106:  return 16'h4000;
            8'd128:  return {7'h00, sec_level, 2'h0, 1'b1, sec_state[3:0], 1'b1};
            default: return 16'h0000;
        endcase
    endfunction : exp_word

    task automatic check_ident();
        logic [7:0]  sum;
        logic [15:0] w;
        sum = 8'ha5;
        for (int i = 0; i < 255; i++)
        begin
            w = exp_word(8'(i));
            sum = sum + w[15:8] + w[7:0];
        end
        tick();
        foreach (idx_list[i])
        begin
            id_idx = idx_list[i];
            tick();
            w = idx_list[i] == 8'hff ? {8'h00 - sum, 8'ha5} : exp_word(idx_list[i]);
            check_word(id_data, w, "identify word");
        end
        $display("test identify done");
    endtask : check_ident

    task automatic run_row(input aic_row_type r);
        host.send_cmd(r.code, r.sc, {4'ha, r.sc[3:0]});
        check_bit(busy, 1'b1, "busy after command");
        tick();
        check_bit(busy, 1'b0, "busy after completion");
        check_bit(drq, r.exp[4], "drq");
        check_bit(intrq, r.exp[3], "interrupt");
        check_bit(aborted, r.exp[2], "abort");
        check_bit(timer_armed, r.exp[1], "standby timer");
        if (r.exp[0])
            check_word({14'h0, pwr_mode}, {14'h0, PWR_IDLE}, "idle mode");
        host.strobe(2'h0, 16'h0000);
        check_bit(intrq, 1'b0, "interrupt after status read");
    endtask : run_row

    task automatic do_reset(input int cnt);
        reset_n = 1'b0;
        repeat (cnt) tick();
        check_bit(busy | drq | intrq | aborted | timer_armed, 1'b0, "reset outputs");
        check_word({14'h0, pwr_mode}, {14'h0, PWR_ACTIVE}, "reset power mode");
        reset_n = 1'b1;
        $display("test reset done");
    endtask : do_reset

    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop

    initial
    begin
        cycles = 0;
        forever
        begin
            @(posedge core_clk);
            cycles++;
            if (cycles == 5000)
            begin
                failures++;
                report_and_stop();
            end
        end
    end

    initial
    begin
        reset_n = 1'b0;
        spindle_turning = 1'b1;
        {udma_act_en, udma_act_mode, sec_state, sec_level} = 10'h000;
        apm_level = 8'h80;
        max_lba = 48'h0012_3456_789a;
        id_idx = 8'h00;
        checked = 0;
        failures = 0;
        do_reset(10);
        check_ident();
        {udma_act_en, udma_act_mode, sec_state, sec_level} = {1'b1, 3'h5, 5'h0b, 1'b1};
        apm_level = 8'hc4;
        max_lba = 48'hfedc_ba98_7654;
        check_ident();
        foreach (rows[i])
            run_row(rows[i]);
        check_word({8'h00, sect_per_track}, 16'h00ff, "sectors per track");
        check_word({12'h000, head_max}, 16'h000f, "heads minus one");
        $display("test command table done");
        host.send_cmd(CMD_WR_BUF, 8'h00, 8'ha0);
        tick();
        check_bit(drq, 1'b1, "write buffer drq");
        for (int i = 0; i < BUF_WORDS; i++)
            host.strobe(2'h1, {8'(i), 8'(255 - i)});
        check_bit(drq | ~intrq, 1'b0, "write buffer end");
        host.strobe(2'h0, 16'h0000);
        // stray word outside the data phase must not land in the buffer
        host.strobe(2'h1, 16'hdead);
        host.send_cmd(CMD_RD_BUF, 8'h00, 8'ha0);
        tick();
        for (int i = 0; i < BUF_WORDS; i++)
        begin
            check_word(rd_data, {8'(i), 8'(255 - i)}, "read back word");
            host.strobe(2'h2, 16'h0000);
        end
        check_bit(drq, 1'b0, "read buffer end");
        $display("test buffer done");
        host.send_cmd(CMD_IDLE_IMM, 8'h00, 8'ha0, 1'b1);
        check_bit(aborted, 1'b0, "command taken while busy");
        check_bit(intrq, 1'b1, "idle immediate interrupt");
        run_row('{CMD_NOP, 8'h00, 5'b01110});
        $display("test busy refusal done");
        spindle_turning = 1'b0;
        host.send_cmd(CMD_IDLE, 8'hff, 8'ha0);
        n = 0;
        while (pwr_mode !== PWR_STANDBY && n < 400)
        begin
            tick();
            n++;
        end
        check_bit(n >= 230 && n <= 250, 1'b1, "standby after one minute");
        $display("test spin-down done");
        do_reset(2);
        report_and_stop();
    end
endmodule : aic_core_tb
